// ---- logic/pwr_state_pkg.sv ----
// Power-state controller constants and types.
// Assumes a single 20 MHz clock domain.
package pwr_state_pkg;
	typedef enum logic [2:0] {
		ST_HW_SHDN = 3'b000,
		ST_TRIM_LOAD = 3'b001,
		ST_SW_SHDN = 3'b010,
		ST_POWERING_UP = 3'b011,
		ST_ACTIVE = 3'b100,
		ST_POWERING_DOWN = 3'b101
	} pwr_state_t;
	localparam int CLK_PERIOD_NS = 50;
	// Ramp time of the amplifier turn-on and turn-off, in ns
	localparam int RAMP_TIME_NS = 1000;
	localparam int RAMP_CYCLES = (RAMP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RAMP_W = 8;
	localparam logic [RAMP_W-1:0] RAMP_LAST = 8'(RAMP_CYCLES - 1);
	localparam logic [RAMP_W-1:0] RAMP_ZERO = 8'h00;
	localparam int SYNC_BITS = 6;
endpackage : pwr_state_pkg

// ---- logic/level_sync.sv ----
// Two-flop synchroniser bank for asynchronous level inputs.
// Assumes one clock; first stage feeds only the second stage.
`timescale 1ns/10ps
module level_sync import pwr_state_pkg::*; #(
	parameter int W = SYNC_BITS,
	parameter logic [SYNC_BITS-1:0] RST_VAL = 6'h00
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	logic [W-1:0] meta_r;
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_ff @(posedge mclk or negedge rstn) begin
				if (!rstn) begin
					meta_r[i] <= RST_VAL[i];
					sync_out[i] <= RST_VAL[i];
				end else begin
					meta_r[i] <= async_in[i];
					sync_out[i] <= meta_r[i];
				end
			end
		end
	endgenerate
endmodule : level_sync

// ---- logic/power_state_controller.sv ----
// Power-state sequencer: hardware shutdown, software shutdown, active.
// Assumes trim loader and amplifier blocks handshake on this clock.
//
// What this block does
// - Exactly three power states exist.
// - Steps between adjacent states; a hardware fault drops straight to hardware shutdown.
// - Normal enable transitions can reverse midway.
// - Fault, supply and reset transitions always complete.
// - Start in hardware shutdown after reset.
// - Hardware shutdown is lowest power configuration.
// - Entering hardware shutdown resets registers and bus.
// - Load trim before entering software shutdown.
// - Trim failure interrupt raised in software shutdown.
// - Low enable pin forces hardware shutdown.
// - Low-voltage supply undervoltage forces hardware shutdown.
// - Exit hardware shutdown when low-voltage supplies and pin good.
// - Low enable pin resets all digital logic.
// - Software shutdown keeps only control bus alive.
// - Global enable moves up/down, raising done pulses.
// - Speaker or battery undervoltage drops to software shutdown.
`timescale 1ns/10ps
module power_state_controller import pwr_state_pkg::*; (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic hw_enable_n,
	input wire logic analog_supply_undervoltage_lockout,
	input wire logic core_supply_undervoltage_lockout,
	input wire logic io_supply_undervoltage_lockout,
	input wire logic speaker_supply_undervoltage_lockout,
	input wire logic battery_supply_undervoltage_lockout,
	input wire logic global_enable,
	input wire logic trim_load_done,
	input wire logic trim_load_ok,
	output logic global_reset_n,
	output logic trim_load_start,
	output logic bus_enable,
	output logic amp_enable,
	output logic [1:0] power_state,
	output logic powerup_complete_irq,
	output logic powerdown_complete_irq,
	output logic trim_fail_irq
);
	// ---------------------------------------------
	// Input synchronisation
	// ---------------------------------------------
	// Reset value: pin low and every supply failed, the safe side
	// Levels only: a glitch shorter than one clock may be missed
	logic [SYNC_BITS-1:0] raw_in;
	logic [SYNC_BITS-1:0] sync_in;
	assign raw_in = {hw_enable_n, analog_supply_undervoltage_lockout,
		core_supply_undervoltage_lockout, io_supply_undervoltage_lockout,
		speaker_supply_undervoltage_lockout, battery_supply_undervoltage_lockout};
	level_sync #(.W(SYNC_BITS), .RST_VAL(6'h1F)) u_sync (
		.mclk(mclk),
		.rstn(rstn),
		.async_in(raw_in),
		.sync_out(sync_in)
	);

	// ---------------------------------------------
	// Condition decode
	// ---------------------------------------------
	// Bit order follows the raw_in packing above
	wire pin_high_s = sync_in[5];
	wire analog_bad_s = sync_in[4];
	wire core_bad_s = sync_in[3];
	wire io_bad_s = sync_in[2];
	wire speaker_bad_s = sync_in[1];
	wire battery_bad_s = sync_in[0];
	wire pin_low = ~pin_high_s;
	wire lv_fault = analog_bad_s | core_bad_s | io_bad_s;
	wire hw_fault = pin_low | lv_fault;
	wire hv_fault = speaker_bad_s | battery_bad_s;
	wire hw_ok = ~hw_fault;
	wire want_up = global_enable & ~hv_fault;

	// ---------------------------------------------
	// State machine
	// ---------------------------------------------
	pwr_state_t state_r, state_nxt;
	logic [RAMP_W-1:0] ramp_r, ramp_nxt;
	logic fail_pend_r, fail_pend_nxt;
	logic forced_r, forced_nxt;
	logic pu_irq_nxt, pd_irq_nxt, fail_irq_nxt;

	always_comb begin
		state_nxt = state_r;
		ramp_nxt = ramp_r;
		fail_pend_nxt = fail_pend_r;
		forced_nxt = forced_r;
		pu_irq_nxt = 1'b0;
		pd_irq_nxt = 1'b0;
		fail_irq_nxt = 1'b0;
		if (hw_fault) begin
			// Forced descent, never cancelled; reset wins any state
			state_nxt = ST_HW_SHDN;
			ramp_nxt = RAMP_ZERO;
			fail_pend_nxt = 1'b0;
			forced_nxt = 1'b0;
		end else begin
			case (state_r)
				ST_HW_SHDN: begin
					if (hw_ok) begin
						state_nxt = ST_TRIM_LOAD;
					end
				end
				ST_TRIM_LOAD: begin
					if (trim_load_done) begin
						fail_pend_nxt = ~trim_load_ok;
						state_nxt = ST_SW_SHDN;
					end
				end
				ST_SW_SHDN: begin
					// Interrupt held until the state is really reached
					if (fail_pend_r) begin
						fail_irq_nxt = 1'b1;
						fail_pend_nxt = 1'b0;
					end
					if (want_up) begin
						state_nxt = ST_POWERING_UP;
						ramp_nxt = RAMP_ZERO;
					end
				end
				ST_POWERING_UP: begin
					if (hv_fault) begin
						state_nxt = ST_POWERING_DOWN;
						forced_nxt = 1'b1;
						ramp_nxt = RAMP_ZERO;
					end else if (!global_enable) begin
						// Reverse from the same ramp point
						state_nxt = ST_POWERING_DOWN;
						ramp_nxt = RAMP_LAST - ramp_r;
					end else if (ramp_r == RAMP_LAST) begin
						state_nxt = ST_ACTIVE;
						pu_irq_nxt = 1'b1;
					end else begin
						ramp_nxt = ramp_r + 8'h01;
					end
				end
				ST_ACTIVE: begin
					if (hv_fault) begin
						state_nxt = ST_POWERING_DOWN;
						forced_nxt = 1'b1;
						ramp_nxt = RAMP_ZERO;
					end else if (!global_enable) begin
						state_nxt = ST_POWERING_DOWN;
						ramp_nxt = RAMP_ZERO;
					end
				end
				ST_POWERING_DOWN: begin
					if (!forced_r && want_up) begin
						state_nxt = ST_POWERING_UP;
						ramp_nxt = RAMP_LAST - ramp_r;
					end else if (ramp_r == RAMP_LAST) begin
						state_nxt = ST_SW_SHDN;
						forced_nxt = 1'b0;
						pd_irq_nxt = ~forced_r;
					end else begin
						ramp_nxt = ramp_r + 8'h01;
					end
				end
				default: begin
					state_nxt = ST_HW_SHDN;
				end
			endcase
		end
	end

	// ---------------------------------------------
	// Output decode
	// ---------------------------------------------
	// Ramp states report as the state being left or approached
	wire [1:0] state_code_nxt = (state_nxt == ST_HW_SHDN || state_nxt == ST_TRIM_LOAD) ? 2'h0 :
		(state_nxt == ST_ACTIVE) ? 2'h2 : 2'h1;
	wire amp_on_nxt = (state_nxt == ST_POWERING_UP) || (state_nxt == ST_ACTIVE) ||
		(state_nxt == ST_POWERING_DOWN);
	wire bus_on_nxt = (state_nxt != ST_HW_SHDN) && (state_nxt != ST_TRIM_LOAD);
	wire trim_go_nxt = (state_r == ST_HW_SHDN) && (state_nxt == ST_TRIM_LOAD);

	// ---------------------------------------------
	// State registers
	// ---------------------------------------------
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			state_r <= ST_HW_SHDN;
			ramp_r <= RAMP_ZERO;
			fail_pend_r <= 1'b0;
			forced_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			ramp_r <= ramp_nxt;
			fail_pend_r <= fail_pend_nxt;
			forced_r <= forced_nxt;
		end
	end

	// ---------------------------------------------
	// Output registers
	// ---------------------------------------------
	// Launched from next state so pins move on the state edge
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			global_reset_n <= 1'b0;
			trim_load_start <= 1'b0;
			bus_enable <= 1'b0;
			amp_enable <= 1'b0;
			power_state <= 2'h0;
			powerup_complete_irq <= 1'b0;
			powerdown_complete_irq <= 1'b0;
			trim_fail_irq <= 1'b0;
		end else begin
			global_reset_n <= (state_nxt != ST_HW_SHDN);
			trim_load_start <= trim_go_nxt;
			bus_enable <= bus_on_nxt;
			amp_enable <= amp_on_nxt;
			power_state <= state_code_nxt;
			powerup_complete_irq <= pu_irq_nxt;
			powerdown_complete_irq <= pd_irq_nxt;
			trim_fail_irq <= fail_irq_nxt;
		end
	end
endmodule : power_state_controller

// ---- tb/trim_loader_model.sv ----
// Trim memory loader seen from the controller.
// Assumes start is a one-cycle pulse on mclk.
`timescale 1ns/10ps
module trim_loader_model (
	input wire logic mclk,
	input wire logic start,
	input wire logic ok_sel,
	output logic done = 1'b0,
	output logic ok = 1'b0
);
	logic [1:0] dly_r = 2'h0;
	// Status toggles outside the answer so a stale value never looks valid
	always @(posedge mclk) begin
		dly_r <= {dly_r[0], start};
		done <= dly_r[1];
		ok <= dly_r[1] ? ok_sel : ~ok;
	end
endmodule : trim_loader_model

// ---- tb/power_state_checker.sv ----
// Port assertions for the power-state controller.
// Assumes a bind onto its top module, one clock domain.
`timescale 1ns/10ps
module power_state_checker (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic hw_enable_n,
	input wire logic analog_supply_undervoltage_lockout,
	input wire logic speaker_supply_undervoltage_lockout,
	input wire logic battery_supply_undervoltage_lockout,
	input wire logic trim_load_done,
	input wire logic global_reset_n,
	input wire logic bus_enable,
	input wire logic amp_enable,
	input wire logic [1:0] power_state,
	input wire logic powerup_complete_irq
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);
	three_states_a: assert property (power_state != 2'h3)
		else $error("bad state code");
	no_skip_a: assert property (power_state == 2'h2 |-> $past(power_state) != 2'h0)
		else $error("skipped state");
	hw_quiet_a: assert property (power_state == 2'h0 |-> !amp_enable && !bus_enable)
		else $error("not quiet");
	pin_down_a: assert property (!hw_enable_n [*3] |=>
		power_state == 2'h0 && !global_reset_n) else $error("pin low ignored");
	lv_down_a: assert property (analog_supply_undervoltage_lockout [*3] |=>
		power_state == 2'h0 && !global_reset_n) else $error("fault ignored");
	trim_first_a: assert property (power_state == 2'h1 && $past(power_state) == 2'h0
		|-> $past(trim_load_done)) else $error("no trim load");
	up_done_a: assert property (powerup_complete_irq |->
		power_state == 2'h2 && $past(power_state) == 2'h1) else $error("stray irq");
	spk_down_a: assert property ((power_state == 2'h2 && (speaker_supply_undervoltage_lockout ||
		battery_supply_undervoltage_lockout)) [*3] |=> power_state != 2'h2) else $error("stays");
	cover property (powerup_complete_irq);
	cover property ($fell(global_reset_n));
	cover property (power_state == 2'h2 && speaker_supply_undervoltage_lockout);
endmodule : power_state_checker

// ---- tb/power_state_controller_tb.sv ----
// Self-checking bench for the power-state controller.
// Assumes the trim loader model answers trim_load_start.
`timescale 1ns/10ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin miscompares++; \
	$display("[ERR] %0t value mismatch", $time); end end
module power_state_controller_tb;
	logic mclk = 1'b0;
	logic rstn = 1'b0;
	logic hw_enable_n = 1'b0;
	logic global_enable = 1'b0;
	logic ok_sel = 1'b0;
	logic [4:0] uv = 5'h1F;
	logic trim_load_done, trim_load_ok, global_reset_n, trim_load_start, bus_enable;
	logic amp_enable, powerup_complete_irq, powerdown_complete_irq, trim_fail_irq;
	logic [1:0] power_state;
	logic [4:0] exp_q[$];
	int miscompares = 0, samples_checked = 0, cyc = 0, n = 0;
	always #25 mclk = ~mclk;
	power_state_controller uut (
		.mclk(mclk),
		.rstn(rstn),
		.hw_enable_n(hw_enable_n),
		.analog_supply_undervoltage_lockout(uv[4]),
		.core_supply_undervoltage_lockout(uv[3]),
		.io_supply_undervoltage_lockout(uv[2]),
		.speaker_supply_undervoltage_lockout(uv[1]),
		.battery_supply_undervoltage_lockout(uv[0]),
		.global_enable(global_enable),
		.trim_load_done(trim_load_done),
		.trim_load_ok(trim_load_ok),
		.global_reset_n(global_reset_n),
		.trim_load_start(trim_load_start),
		.bus_enable(bus_enable),
		.amp_enable(amp_enable),
		.power_state(power_state),
		.powerup_complete_irq(powerup_complete_irq),
		.powerdown_complete_irq(powerdown_complete_irq),
		.trim_fail_irq(trim_fail_irq)
	);
	trim_loader_model tlm (.mclk(mclk), .start(trim_load_start), .ok_sel(ok_sel),
		.done(trim_load_done), .ok(trim_load_ok));
	task automatic end_of_test;
		if (miscompares == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : end_of_test
	// Bounded so a stuck state falls through to the next compare
	task automatic wait_st(input logic [1:0] s);
		n = 0;
		while (power_state !== s && n < 300) begin
			@(negedge mclk);
			n++;
		end
	endtask : wait_st
	// Ramp states report as software shutdown, so ramp end shows on amp_enable
	task automatic wait_amp(input logic lvl);
		n = 0;
		while (amp_enable !== lvl && n < 300) begin
			@(negedge mclk);
			n++;
		end
	endtask : wait_amp
	// Event watcher: oldest note against each interrupt pulse
	always @(negedge mclk) begin
		cyc++;
		if (cyc == 3000) begin
			miscompares++;
			end_of_test();
		end
		if (powerup_complete_irq | powerdown_complete_irq | trim_fail_irq)
			`CHK({powerup_complete_irq, powerdown_complete_irq, trim_fail_irq, power_state}, exp_q.size() ? exp_q.pop_front() : 5'h1F)
	end
	// ----------------
	// Main sequence
	// ----------------
	initial begin
		void'($urandom(32'h7913));
		repeat (3) @(negedge mclk);
		rstn = 1'b1;
		exp_q.push_back(5'h05);
		hw_enable_n = 1'b1;
		uv = 5'h00;
		wait_st(2'h1);
		`CHK({global_reset_n, bus_enable, amp_enable}, 3'b110)
		exp_q.push_back(5'h12);
		global_enable = 1'b1;
		wait_st(2'h2);
		`CHK(n, 21)
		exp_q.push_back(5'h12);
		global_enable = 1'b0;
		repeat (3 + $urandom % 10) @(negedge mclk);
		global_enable = 1'b1;
		wait_st(2'h2);
		`CHK(n < 21, 1'b1)
		exp_q.push_back(5'h09);
		global_enable = 1'b0;
		wait_amp(1'b0);
		`CHK(n, 21)
		exp_q.push_back(5'h12);
		global_enable = 1'b1;
		wait_st(2'h2);
		uv = ($urandom % 2) ? 5'h01 : 5'h02;
		wait_st(2'h1);
		repeat (30) @(negedge mclk);
		`CHK({power_state, amp_enable}, 3'b010)
		hw_enable_n = 1'b0;
		wait_st(2'h0);
		`CHK({global_reset_n, bus_enable}, 2'b00)
		global_enable = 1'b0;
		uv = 5'h00;
		for (int i = 0; i < 3; i++) begin
			hw_enable_n = 1'b1;
			ok_sel = 1'($urandom);
			if (!ok_sel)
				exp_q.push_back(5'h05);
			wait_st(2'h1);
			uv = 5'h10 >> i;
			wait_st(2'h0);
			`CHK(global_reset_n, 1'b0)
			uv = 5'h00;
		end
		`CHK(exp_q.size(), 0)
		end_of_test();
	end
endmodule : power_state_controller_tb
bind power_state_controller power_state_checker chk (.*);
